// >>> rtl/tlpm_pkg.sv
// tlpm_pkg: register map, field positions and reset values of the travel
// limit and position error monitor.
// assumes a 32-bit APB slave with one aligned word per register.
package tlpm_pkg;
  localparam int TLPM_AW = 8;
  localparam int TLPM_DW = 32;
  localparam int TLPM_NEVT = 3;
  // byte offsets
  localparam logic [TLPM_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [TLPM_AW-1:0] OFF_ERRLIM = 8'h04;
  localparam logic [TLPM_AW-1:0] OFF_SOFTPOS = 8'h08;
  localparam logic [TLPM_AW-1:0] OFF_SOFTNEG = 8'h0c;
  localparam logic [TLPM_AW-1:0] OFF_ERRCNT = 8'h10;
  localparam logic [TLPM_AW-1:0] OFF_CMDPOS = 8'h14;
  localparam logic [TLPM_AW-1:0] OFF_STATUS = 8'h18;
  localparam logic [TLPM_AW-1:0] OFF_INTSTAT = 8'h1c;
  localparam logic [TLPM_AW-1:0] OFF_INTMASK = 8'h20;
  // control fields
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  // event and status fields
  localparam int EVT_EXCESS = 0;
  localparam int EVT_SOFT = 1;
  localparam int EVT_HARD = 2;
  localparam int ST_POSOUT = 3;
  localparam int ST_NEGOUT = 4;
  // limit sensor vector positions
  localparam int LIM_POS = 0;
  localparam int LIM_NEG = 1;
  localparam int LIM_CLR = 2;
  localparam int LIM_N = 3;
  // reset values
  localparam logic [TLPM_DW-1:0] ERRLIM_RST = 32'h00030d40;
  localparam logic [TLPM_DW-1:0] SOFTPOS_RST = 32'h7fffffff;
  localparam logic [TLPM_DW-1:0] SOFTNEG_RST = 32'h80000000;
  localparam logic [TLPM_DW-1:0] ZERO_RST = 32'h00000000;
  localparam logic [TLPM_NEVT-1:0] MASK_RST = 3'h0;
endpackage : tlpm_pkg

// >>> rtl/tlpm_sync.sv
// tlpm_sync: two-flop synchroniser, one per bit of the vector.
// assumes inputs are asynchronous pins; ce freezes the chain.
`timescale 1ns/10ps
module tlpm_sync #(
  parameter int N = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [N-1:0] asyncIn,
  output logic [N-1:0] syncOut
);
  logic [N-1:0] stage1_q;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          stage1_q[gi] <= 1'b0;
          syncOut[gi] <= 1'b0;
        end else if (ce) begin
          stage1_q[gi] <= asyncIn[gi];
          syncOut[gi] <= stage1_q[gi];
        end
      end
    end
  endgenerate
endmodule : tlpm_sync

// >>> rtl/tlpm_monitor.sv
// tlpm_monitor: position error, software and hardware over-travel supervision
// with an APB register file and a masked level interrupt.
// assumes servoTick, cmdDelta and measPos come from logic on clk; limit
// sensor and alarm-clear pins are asynchronous.
`timescale 1ns/10ps
module tlpm_monitor
  import tlpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TLPM_AW-1:0] paddr,
  input wire logic [TLPM_DW-1:0] pwdata,
  output logic [TLPM_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // motion path and feedback
  input wire logic servoTick,
  input wire logic signed [TLPM_DW-1:0] cmdDelta,
  input wire logic signed [TLPM_DW-1:0] measPos,
  // pins
  input wire logic positiveLimit,
  input wire logic negativeLimit,
  input wire logic alarmClearInput,
  // warnings and intrusion outputs
  output logic excessErrorWarning,
  output logic softOvertravelWarning,
  output logic hardOvertravelWarning,
  output logic positiveIntrusionOutput,
  output logic negativeIntrusionOutput,
  output logic irq
);
  logic [LIM_N-1:0] pinSync;
  logic [TLPM_DW-1:0] errLimit_q;
  logic signed [TLPM_DW-1:0] softPos_q;
  logic signed [TLPM_DW-1:0] softNeg_q;
  logic signed [TLPM_DW-1:0] cmdPos_q;
  logic signed [TLPM_DW-1:0] cmdPos_d;
  logic signed [TLPM_DW-1:0] posErr_q;
  logic signed [TLPM_DW-1:0] lastMeas_q;
  logic scaleDir_q;
  logic polNo_q;
  logic clrCmd_q;
  logic hwPos_q;
  logic hwNeg_q;
  logic softPosOut_q;
  logic softNegOut_q;
  logic [TLPM_NEVT-1:0] intStat_q;
  logic [TLPM_NEVT-1:0] intMask_q;
  logic [TLPM_NEVT-1:0] evtPrev_q;

  tlpm_sync #(.N(LIM_N)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .asyncIn({alarmClearInput, negativeLimit, positiveLimit}),
    .syncOut(pinSync)
  );

  // apb decode
  wire access = psel & penable;
  wire wrEn = access & pwrite & pready;
  wire rdLoad = access & ~pready;
  wire hitCtrl = paddr == OFF_CTRL;
  wire hitLim = paddr == OFF_ERRLIM;
  wire hitSp = paddr == OFF_SOFTPOS;
  wire hitSn = paddr == OFF_SOFTNEG;
  wire hitEc = paddr == OFF_ERRCNT;
  wire hitCp = paddr == OFF_CMDPOS;
  wire hitSt = paddr == OFF_STATUS;
  wire hitIs = paddr == OFF_INTSTAT;
  wire hitIm = paddr == OFF_INTMASK;
  wire mapped = hitCtrl | hitLim | hitSp | hitSn | hitEc | hitCp | hitSt |
                hitIs | hitIm;

  // alarm clear from pin or from the command bit
  wire clrAny = pinSync[LIM_CLR] | clrCmd_q;

  // error magnitude compared every cycle
  wire [TLPM_DW-1:0] errMag = posErr_q[TLPM_DW-1] ?
                              TLPM_DW'(-posErr_q) : TLPM_DW'(posErr_q);
  wire excessCond = errMag >= errLimit_q;

  // commanded position is measured plus error
  wire signed [TLPM_DW-1:0] cmdView = measPos + posErr_q;
  wire softPosSide = cmdView >= softPos_q;
  wire softNegSide = cmdView <= softNeg_q;

  // sensor active level: open contact with normally closed polarity
  wire posActive = polNo_q ? pinSync[LIM_POS] : ~pinSync[LIM_POS];
  wire negActive = polNo_q ? pinSync[LIM_NEG] : ~pinSync[LIM_NEG];
  wire movedNeg = servoTick & (measPos < lastMeas_q);
  wire movedPos = servoTick & (measPos > lastMeas_q);
  wire hwPos_d = posActive | (hwPos_q & ~movedNeg);
  wire hwNeg_d = negActive | (hwNeg_q & ~movedPos);

  // moves toward a latched limit are dropped, moves away pass
  wire blockMove = (hwPos_q & (cmdDelta > 0)) |
                   (hwNeg_q & (cmdDelta < 0));
  assign cmdPos_d = blockMove ? cmdPos_q : cmdPos_q + cmdDelta;

  wire [TLPM_NEVT-1:0] evtNow = {hwPos_d | hwNeg_d,
                                 softPosSide | softNegSide,
                                 excessCond | (excessErrorWarning & ~clrAny)};
  wire [TLPM_NEVT-1:0] evtRise = evtNow & ~evtPrev_q;
  wire [TLPM_NEVT-1:0] w1c = (wrEn & hitIs) ? pwdata[TLPM_NEVT-1:0] : 3'h0;
  wire [TLPM_NEVT-1:0] intStat_d = evtRise | (intStat_q & ~w1c);

  wire [TLPM_DW-1:0] ctrlRd = {29'h0, polNo_q, scaleDir_q, 1'b0};
  wire [TLPM_DW-1:0] statRd = {27'h0, negativeIntrusionOutput,
                               positiveIntrusionOutput, hardOvertravelWarning,
                               softOvertravelWarning, excessErrorWarning};
  wire [TLPM_DW-1:0] rdMux =
    hitCtrl ? ctrlRd :
    hitLim ? errLimit_q :
    hitSp ? softPos_q :
    hitSn ? softNeg_q :
    hitEc ? posErr_q :
    hitCp ? cmdPos_q :
    hitSt ? statRd :
    hitIs ? {29'h0, intStat_q} :
    hitIm ? {29'h0, intMask_q} : ZERO_RST;

  // bus answer: one wait state, data and error set with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= ZERO_RST;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= rdLoad;
      prdata <= rdLoad ? rdMux : ZERO_RST;
      pslverr <= rdLoad & ~mapped;
    end
  end

  // software settings
  always_ff @(posedge clk) begin
    if (rst) begin
      errLimit_q <= ERRLIM_RST;
      softPos_q <= SOFTPOS_RST;
      softNeg_q <= SOFTNEG_RST;
      scaleDir_q <= 1'b0;
      polNo_q <= 1'b0;
      clrCmd_q <= 1'b0;
      intMask_q <= MASK_RST;
    end else if (ce) begin
      clrCmd_q <= wrEn & hitCtrl & pwdata[CTRL_CLR_BIT];
      if (wrEn & hitLim) errLimit_q <= pwdata;
      if (wrEn & hitSp) softPos_q <= pwdata;
      if (wrEn & hitSn) softNeg_q <= pwdata;
      if (wrEn & hitIm) intMask_q <= pwdata[TLPM_NEVT-1:0];
      if (wrEn & hitCtrl) begin
        scaleDir_q <= pwdata[CTRL_DIR_BIT];
        polNo_q <= pwdata[CTRL_POL_BIT];
      end
    end
  end

  // servo-cycle counters
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdPos_q <= ZERO_RST;
      posErr_q <= ZERO_RST;
      lastMeas_q <= ZERO_RST;
    end else if (ce && servoTick) begin
      cmdPos_q <= cmdPos_d;
      posErr_q <= cmdPos_q - measPos;
      lastMeas_q <= measPos;
    end
  end

  // warnings, intrusion side and interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      excessErrorWarning <= 1'b0;
      softOvertravelWarning <= 1'b0;
      hardOvertravelWarning <= 1'b0;
      hwPos_q <= 1'b0;
      hwNeg_q <= 1'b0;
      softPosOut_q <= 1'b0;
      softNegOut_q <= 1'b0;
      positiveIntrusionOutput <= 1'b0;
      negativeIntrusionOutput <= 1'b0;
      intStat_q <= 3'h0;
      evtPrev_q <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      excessErrorWarning <= evtNow[EVT_EXCESS];
      softOvertravelWarning <= softPosSide | softNegSide;
      hwPos_q <= hwPos_d;
      hwNeg_q <= hwNeg_d;
      hardOvertravelWarning <= hwPos_d | hwNeg_d;
      softPosOut_q <= softPosSide;
      softNegOut_q <= softNegSide;
      positiveIntrusionOutput <= scaleDir_q ? softNegSide : softPosSide;
      negativeIntrusionOutput <= scaleDir_q ? softPosSide : softNegSide;
      intStat_q <= intStat_d;
      evtPrev_q <= evtNow;
      irq <= |(intStat_d & intMask_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_err_difference: assert property (
    ce && servoTick |=> posErr_q == $past(cmdPos_q) - $past(measPos))
    else $error("position error is not command minus measured");

  a_excess_set: assert property (
    ce && excessCond |=> excessErrorWarning)
    else $error("excess warning missing at or above the limit");

  a_limit_default: assert property (disable iff (1'b0)
    rst |=> errLimit_q == 32'h00030d40)
    else $error("error limit not at its reset value");

  a_excess_clear: assert property (
    ce && clrAny && !excessCond |=> !excessErrorWarning)
    else $error("excess warning survived an alarm clear");

  a_excess_hold: assert property (
    ce && excessErrorWarning && !clrAny |=> excessErrorWarning)
    else $error("excess warning dropped without a clear");

  a_soft_region: assert property (
    ce && (cmdView >= softPos_q || cmdView <= softNeg_q) |=>
      softOvertravelWarning)
    else $error("software over-travel not raised in forbidden region");

  a_soft_side: assert property (
    ce && softPosSide && !softNegSide |=>
      ($past(scaleDir_q) ? negativeIntrusionOutput : positiveIntrusionOutput)
      && softPosOut_q)
    else $error("wrong intrusion output for positive entry");

  a_dir_swap: assert property (
    ce && softNegSide && !softPosSide && scaleDir_q |=>
      positiveIntrusionOutput && !negativeIntrusionOutput)
    else $error("scale direction swap not applied");

  a_nc_default: assert property (
    ce && !polNo_q && !pinSync[LIM_POS] |=> hwPos_q && hardOvertravelWarning)
    else $error("open positive limit input not treated as active");

  a_hw_latched: assert property (
    ce && hwPos_q && !posActive && !movedNeg |=> hwPos_q)
    else $error("hardware over-travel released without reverse motion");

  a_move_blocked: assert property (
    ce && servoTick && hwPos_q && cmdDelta > 0 |=> cmdPos_q == $past(cmdPos_q))
    else $error("move into a latched positive limit was accepted");

  a_move_away: assert property (
    ce && servoTick && hwPos_q && !hwNeg_q && cmdDelta < 0 |=>
      cmdPos_q == $past(cmdPos_q) + $past(cmdDelta))
    else $error("move leaving the limit region was refused");

  a_err_readout: assert property (
    ce && hitEc && rdLoad |=> prdata == $past(posErr_q))
    else $error("position error readout differs from the counter");

  a_limit_write: assert property (
    ce && wrEn && hitLim |=> errLimit_q == $past(pwdata))
    else $error("error limit write did not land");

  a_soft_clear: assert property (
    ce && !softPosSide && !softNegSide |=> !softOvertravelWarning)
    else $error("software over-travel raised outside forbidden region");

  a_soft_negside: assert property (
    ce && softNegSide && !softPosSide |=>
      ($past(scaleDir_q) ? positiveIntrusionOutput : negativeIntrusionOutput)
      && softNegOut_q)
    else $error("wrong intrusion output for negative entry");

  a_hw_follow: assert property (
    ce && (posActive || negActive) |=> hardOvertravelWarning)
    else $error("active limit sensor did not raise hardware warning");

  a_neg_latched: assert property (
    ce && hwNeg_q && !negActive && !movedPos |=> hwNeg_q)
    else $error("negative over-travel released without reverse motion");

  a_neg_blocked: assert property (
    ce && servoTick && hwNeg_q && cmdDelta < 0 |=>
      cmdPos_q == $past(cmdPos_q))
    else $error("move into a latched negative limit was accepted");
endmodule : tlpm_monitor

// >>> testbench/tlpm_limit_model.sv
// tlpm_limit_model: pair of normally closed limit switches on the axis.
// assumes motorPos is the actual motor position driven by the bench.
`timescale 1ns/10ps
module tlpm_limit_model #(
  parameter int POS_END = 5000,
  parameter int NEG_END = -5000
) (
  // axis
  input wire logic signed [31:0] motorPos,
  input wire logic wired,
  // switch pins
  output logic positiveLimit,
  output logic negativeLimit
);
  // closed contact holds the pin high; a loose wire reads low
  assign positiveLimit = wired && (motorPos < POS_END);
  assign negativeLimit = wired && (motorPos > NEG_END);
endmodule : tlpm_limit_model

// >>> testbench/test_travel_limit_position_error_monitor.sv
// test_travel_limit_position_error_monitor: random and corner checks of
// the monitor over APB; assumes tlpm_limit_model for the limit pins.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nFail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_travel_limit_position_error_monitor
  import tlpm_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] seed = 32'h000160b7;
  logic [31:0] prdata;
  logic pready, pslverr, err, irq, positiveLimit, negativeLimit;
  logic servoTick = 0;
  logic alarmClearInput = 0;
  logic wired = 0;
  logic signed [31:0] cmdDelta = 32'h0;
  logic signed [31:0] measPos = 32'h0;
  logic signed [31:0] expCmd = 32'h0;
  logic excessErrorWarning, softOvertravelWarning, hardOvertravelWarning;
  logic positiveIntrusionOutput, negativeIntrusionOutput;
  int nFail = 0;
  int checked = 0;

  tlpm_monitor tlpm_monitor_i (.clk, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .servoTick, .cmdDelta,
    .measPos, .positiveLimit, .negativeLimit, .alarmClearInput,
    .excessErrorWarning, .softOvertravelWarning, .hardOvertravelWarning,
    .positiveIntrusionOutput, .negativeIntrusionOutput, .irq);
  tlpm_limit_model tlpm_limit_model_i (.motorPos(measPos), .wired,
    .positiveLimit, .negativeLimit);

  always #20 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic overLimit(input int e, input int l);
    return ((e < 0) ? -e : e) >= l;
  endfunction : overLimit

  task automatic testDone();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : testDone

  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic tick(input int d, input int m);
    @(posedge clk);
    servoTick <= 1;
    cmdDelta <= d;
    measPos <= m;
    @(posedge clk);
    servoTick <= 0;
    repeat (4) @(posedge clk);
  endtask : tick

  initial begin
    #(40 * 20000);
    nFail++;
    testDone();
  end

  initial begin
    int lim;
    int d;
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    `CHK(hardOvertravelWarning, 1'b1)
    apb(0, OFF_ERRLIM, 32'h0);
    `CHK(rd, ERRLIM_RST)
    apb(0, OFF_SOFTPOS, 32'h0);
    `CHK(rd, SOFTPOS_RST)
    apb(0, OFF_SOFTNEG, 32'h0);
    `CHK(rd, SOFTNEG_RST)
    apb(0, 8'h24, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    wired <= 1;
    tick(0, 0);
    `CHK(hardOvertravelWarning, 1'b1)
    tick(0, -1);
    tick(0, 0);
    `CHK(hardOvertravelWarning, 1'b0)
    apb(1, OFF_INTMASK, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1, OFF_INTSTAT, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    seed = lfsr(seed);
    lim = seed[7:0] + 2;
    apb(1, OFF_ERRLIM, lim);
    apb(0, OFF_ERRLIM, 32'h0);
    `CHK(rd, lim)
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? lim : (i == 1) ? -lim : (i == 2) ? lim - 1 :
          {{23{seed[8]}}, seed[8:0]};
      tick(d, 0);
      tick(0, 0);
      expCmd += d;
      apb(0, OFF_ERRCNT, 32'h0);
      `CHK(rd, expCmd)
      `CHK(excessErrorWarning, overLimit(expCmd, lim))
      if (i == 0) begin
        `CHK(irq, 1'b1)
        apb(1, OFF_INTMASK, 32'h0);
      end
      tick(-d, 0);
      tick(0, 0);
      expCmd -= d;
      if (i[0]) begin
        apb(1, OFF_CTRL, 32'h1);
      end else begin
        alarmClearInput <= 1;
        repeat (4) @(posedge clk);
        alarmClearInput <= 0;
      end
      repeat (4) @(posedge clk);
      `CHK(excessErrorWarning, 1'b0)
    end
    apb(0, OFF_INTSTAT, 32'h0);
    `CHK({irq, rd[0]}, 2'b01)
    apb(1, OFF_INTSTAT, 32'h7);
    apb(0, OFF_INTSTAT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1, OFF_ERRLIM, 32'h00100000);
    apb(1, OFF_SOFTPOS, 32'h000003e8);
    apb(1, OFF_SOFTNEG, 32'hfffffc18);
    for (int k = 0; k < 4; k++) begin
      apb(1, OFF_CTRL, {30'h0, k[1], 1'b0});
      d = k[0] ? 1000 : -1000;
      tick(d, 0);
      tick(0, 0);
      `CHK(softOvertravelWarning, 1'b1)
      `CHK(positiveIntrusionOutput, k[0] ^ k[1])
      `CHK(negativeIntrusionOutput, ~(k[0] ^ k[1]))
      tick(-d, 0);
      tick(0, 0);
      `CHK(softOvertravelWarning, 1'b0)
    end
    tick(0, 1500);
    tick(0, 1500);
    `CHK(softOvertravelWarning, 1'b0)
    tick(0, 6000);
    `CHK(hardOvertravelWarning, 1'b1)
    tick(50, 6000);
    tick(-50, 6000);
    expCmd -= 50;
    apb(0, OFF_CMDPOS, 32'h0);
    `CHK(rd, expCmd)
    tick(0, 4000);
    `CHK(hardOvertravelWarning, 1'b1)
    tick(0, 3990);
    `CHK(hardOvertravelWarning, 1'b0)
    // normally open polarity: closed contacts now read as active
    apb(1, OFF_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    `CHK(hardOvertravelWarning, 1'b1)
    apb(1, OFF_CTRL, 32'h0);
    tick(0, 3970);
    tick(0, 3980);
    `CHK(hardOvertravelWarning, 1'b0)
    // a servo tick while ce is low must not move the command
    ce <= 0;
    tick(77, 3980);
    ce <= 1;
    apb(0, OFF_CMDPOS, 32'h0);
    `CHK(rd, expCmd)
    testDone();
  end
endmodule : test_travel_limit_position_error_monitor
